// ==== hdl/dvr_pkg.sv ====
package dvr_pkg;

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam logic [4:0] BIT_LAST = 5'h17;     // Index of the 24th bit of a frame.
    localparam int CMD_MSB = 23;                 // Command nibble, top of the frame.
    localparam int CMD_LSB = 20;
    localparam int ADDR_MSB = 19;                // Address nibble.
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 15;                // Data field, low 16 bits.
    localparam int HEAD_LSB = 16;                // Command and address byte, echoed first.

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_RESTORE = 4'h1;
    localparam logic [3:0] CMD_SAVE = 4'h2;
    localparam logic [3:0] CMD_USER_WR = 4'h3;
    localparam logic [3:0] CMD_RESTORE_ALL = 4'h8;
    localparam logic [3:0] CMD_NV_RD = 4'h9;
    localparam logic [3:0] CMD_WIPER_RD = 4'ha;
    localparam logic [3:0] CMD_LOAD = 4'hb;
    localparam logic [3:0] CMD_SHIFT_L = 4'hc;
    localparam logic [3:0] CMD_INC = 4'he;

    // ------------------------------------------------------------------
    // Wiper codes and nonvolatile map
    // ------------------------------------------------------------------
    localparam logic [9:0] WIPER_FULL = 10'h3ff;  // Full scale.
    localparam logic [9:0] WIPER_MID = 10'h200;   // Midscale.
    localparam logic [5:0] WIPER_PAD = 6'h00;     // Zero bits above a wiper in a 16-bit word.
    localparam int NV_DEPTH = 16;                 // Slots 0..1, user 2..14, 15 unused.
    localparam logic [3:0] ADDR_SLOT1 = 4'h0;
    localparam logic [3:0] ADDR_SLOT2 = 4'h1;
    localparam logic [3:0] ADDR_USER_FIRST = 4'h2;
    localparam logic [3:0] ADDR_USER_LAST = 4'he;
    localparam logic [15:0] NV_USER_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Types and shared arithmetic
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        BOOT_S = 4'b0001,
        IDLE_S = 4'b0010,
        EXEC_S = 4'b0100,
        FETCH_S = 4'b1000
    } dvr_state_type;

    // One step up; the top code holds rather than wrapping to zero.
    function automatic logic [9:0] dvr_wiper_inc(input logic [9:0] w);
        return (w == WIPER_FULL) ? w : w + 10'h001;
    endfunction

    // Doubling; anything at or above midscale lands on full scale.
    function automatic logic [9:0] dvr_wiper_dbl(input logic [9:0] w);
        return w[9] ? WIPER_FULL : {w[8:0], 1'b0};
    endfunction

endpackage

// ==== hdl/dvr_link_if.sv ====
`timescale 1ns/1ps
// Carries finished frames to the core and readback words back to the link.
interface dvr_link_if;
    logic frame_tgl;          // Toggles once per completed frame (link clock).
    logic [23:0] frame_word;  // Last frame received, stable until the next ends.
    logic rd_sel;             // Core level: next frame returns rd_word in its low bits.
    logic [15:0] rd_word;     // Readback data, stable while rd_sel is high.

    modport link (output frame_tgl, output frame_word, input rd_sel, input rd_word);
    modport core (input frame_tgl, input frame_word, output rd_sel, output rd_word);
endinterface

// ==== hdl/dvr_link.sv ====
`timescale 1ns/1ps
module dvr_link
    import dvr_pkg::*;
(
    // Serial pins.
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic serial_data_in_i,
    output logic serial_data_out_o,
    // Reset and core side.
    input wire logic sys_rst_i,
    dvr_link_if.link lnk
);

    // ------------------------------------------------------------------
    // Link state
    // ------------------------------------------------------------------
    logic [4:0] bit_cnt;      // Rising edges seen in this frame.
    logic [22:0] shreg;       // Bits received so far.
    logic rs_s1;              // Readback select, first synchroniser stage.
    logic rs_s2;              // Readback select, usable stage.
    logic [23:0] tx_word;     // Word being returned this frame.

    // The serial clock stops between frames, so these flops cannot wait
    // for an edge to leave reset; they clear asynchronously to constants.
    always_ff @(posedge spi_sclk_i or posedge sys_rst_i or posedge spi_cs_n_i) begin
        if (sys_rst_i || spi_cs_n_i) begin
            bit_cnt <= 5'h00;
        end else if (bit_cnt == BIT_LAST) begin
            bit_cnt <= 5'h00;
        end else begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    // Both clocking modes sample on the rising edge.
    always_ff @(posedge spi_sclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            shreg <= '0;
            lnk.frame_word <= '0;
            lnk.frame_tgl <= 1'b0;
            rs_s1 <= 1'b0;
            rs_s2 <= 1'b0;
        end else begin
            shreg <= {shreg[21:0], serial_data_in_i};
            rs_s1 <= lnk.rd_sel;
            rs_s2 <= rs_s1;
            if (!spi_cs_n_i && bit_cnt == BIT_LAST) begin
                lnk.frame_word <= {shreg, serial_data_in_i};
                lnk.frame_tgl <= ~lnk.frame_tgl;
            end
        end
    end

    // Head byte always echoes the last command; low bits are echo or readback.
    always_comb begin
        tx_word = {lnk.frame_word[CMD_MSB:HEAD_LSB], lnk.frame_word[DATA_MSB:0]};
        if (rs_s2) begin
            tx_word = {lnk.frame_word[CMD_MSB:HEAD_LSB], lnk.rd_word};
        end
    end

    // Output changes on the falling edge; bit 23 is ready before the
    // first sampling edge in either mode.
    always_ff @(negedge spi_sclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            serial_data_out_o <= 1'b0;
        end else begin
            serial_data_out_o <= tx_word[BIT_LAST - bit_cnt];
        end
    end

endmodule // dvr_link

// ==== hdl/dvr_nvstore.sv ====
`timescale 1ns/1ps
module dvr_nvstore
    import dvr_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Write port.
    input wire logic we_i,
    input wire logic [3:0] waddr_i,
    input wire logic [15:0] wdata_i,
    // Read ports.
    input wire logic [3:0] raddr_i,
    output logic [15:0] rdata_o,
    output logic [15:0] slot1_o,
    output logic [15:0] slot2_o
);

    // ------------------------------------------------------------------
    // Storage array
    // ------------------------------------------------------------------
    logic [15:0] mem [NV_DEPTH];  // Wiper slots and user words.

    // Reset stands in for factory contents: a logic model cannot keep
    // data through power loss, so slots come up at midscale.
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < NV_DEPTH; i++) begin
                mem[i] <= NV_USER_RESET;
            end
            mem[ADDR_SLOT1] <= {WIPER_PAD, WIPER_MID};
            mem[ADDR_SLOT2] <= {WIPER_PAD, WIPER_MID};
            rdata_o <= '0;
        end else begin
            if (we_i) begin
                mem[waddr_i] <= wdata_i;
            end
            rdata_o <= mem[raddr_i];
        end
    end

    // Slots are read continuously so a restore needs no wait state.
    assign slot1_o = mem[ADDR_SLOT1];
    assign slot2_o = mem[ADDR_SLOT2];

endmodule // dvr_nvstore

// ==== hdl/dvr_top.sv ====
`timescale 1ns/1ps
// What this block does
// - Load code, address 0: wiper 1 takes data.
// - Load code, address 1: wiper 2 takes data.
// - Code 200 hex is midscale.
// - Increment command adds one to wiper.
// - Save command copies wiper into nonvolatile slot.
// - Restore command copies slot back to wiper.
// - Power-on and preset strobe restore both wipers.
// - Upper nibble 8 restores both wipers.
// - No-operation returns block to idle.
// - Command 3 stores data in user word.
// - Thirteen user words of sixteen bits.
// - Command 9 fetches location for next frame.
// - Next frame returns head byte plus data.
// - Shift-left command doubles the addressed wiper.
// - Shift-left works on either channel.
// - Command A0 prepares wiper readback.
// - Slave in both supported clocking modes.
module dvr_top
(
    // System clock and reset.
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Serial port.
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic serial_data_in_i,
    output logic serial_data_out_o,
    // Control pins.
    input wire logic preset_strobe_n_i,
    input wire logic write_protect_n_i,
    // Wiper codes and power state.
    output logic [9:0] wiper_reg_1_o,
    output logic [9:0] wiper_reg_2_o,
    output logic idle_o
);
    import dvr_pkg::*;

    // ------------------------------------------------------------------
    // Core state
    // ------------------------------------------------------------------
    typedef struct packed {
        dvr_state_type state;  // Sequencer state.
        logic pr_s1;           // Preset strobe, first synchroniser stage.
        logic pr_s2;           // Preset strobe, usable stage.
        logic wp_s1;           // Write protect, first synchroniser stage.
        logic wp_s2;           // Write protect, usable stage.
        logic tg_s1;           // Frame toggle, first synchroniser stage.
        logic tg_s2;           // Frame toggle, second stage.
        logic tg_s3;           // Frame toggle, delayed copy for edge detect.
        logic [23:0] cmd_word; // Frame under decode.
        logic [9:0] wiper1;    // Wiper register 1.
        logic [9:0] wiper2;    // Wiper register 2.
        logic rd_sel;          // Readback prepared for the next frame.
        logic [15:0] rd_word;  // Readback data.
        logic idle;            // Low-power idle indication.
        logic nv_we;           // Nonvolatile write strobe.
        logic [3:0] nv_waddr;  // Nonvolatile write address.
        logic [15:0] nv_wdata; // Nonvolatile write data.
    } dvr_core_type;

    dvr_core_type r;       // Registered state.
    dvr_core_type next_r;  // Next state.

    dvr_link_if lnk ();    // Link to the serial-clock side.

    logic [15:0] nv_rdata; // Registered read of the addressed location.
    logic [15:0] slot1;    // Nonvolatile slot 1 contents.
    logic [15:0] slot2;    // Nonvolatile slot 2 contents.
    logic frame_evt;       // One-cycle pulse per completed frame.
    logic [3:0] cmd;       // Command nibble of the frame under decode.
    logic [3:0] addr;      // Address nibble of the frame under decode.
    logic [15:0] data;     // Data field of the frame under decode.
    logic chan2;           // Address selects channel 2.

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    dvr_link u_link (
        .spi_sclk_i(spi_sclk_i),
        .spi_cs_n_i(spi_cs_n_i),
        .serial_data_in_i(serial_data_in_i),
        .serial_data_out_o(serial_data_out_o),
        .sys_rst_i(sys_rst_i),
        .lnk(lnk)
    );

    dvr_nvstore u_nv (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .we_i(r.nv_we),
        .waddr_i(r.nv_waddr),
        .wdata_i(r.nv_wdata),
        .raddr_i(addr),
        .rdata_o(nv_rdata),
        .slot1_o(slot1),
        .slot2_o(slot2)
    );

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    assign cmd = r.cmd_word[CMD_MSB:CMD_LSB];
    assign addr = r.cmd_word[ADDR_MSB:ADDR_LSB];
    assign data = r.cmd_word[DATA_MSB:0];
    assign chan2 = (addr == ADDR_SLOT2);
    // Only the second and third toggle stages are compared, never the first.
    assign frame_evt = r.tg_s2 ^ r.tg_s3;

    // Readback travels to the link as levels that stay put for a whole
    // frame; the link resynchronises the select before it uses it.
    assign lnk.rd_sel = r.rd_sel;
    assign lnk.rd_word = r.rd_word;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.nv_we = 1'b0;
        // Synchronisers: each first stage feeds only its second stage.
        next_r.pr_s1 = preset_strobe_n_i;
        next_r.pr_s2 = r.pr_s1;
        next_r.wp_s1 = write_protect_n_i;
        next_r.wp_s2 = r.wp_s1;
        next_r.tg_s1 = lnk.frame_tgl;
        next_r.tg_s2 = r.tg_s1;
        next_r.tg_s3 = r.tg_s2;

        case (r.state)
            BOOT_S: begin
                // Power-on restore, without any serial command.
                next_r.wiper1 = slot1[9:0];
                next_r.wiper2 = slot2[9:0];
                next_r.state = IDLE_S;
            end
            IDLE_S: begin
                if (!r.pr_s2) begin
                    // Preset held low keeps both wipers on the stored values.
                    next_r.wiper1 = slot1[9:0];
                    next_r.wiper2 = slot2[9:0];
                end
                // A frame is still taken during preset so none is lost.
                if (frame_evt) begin
                    next_r.cmd_word = lnk.frame_word;
                    next_r.state = EXEC_S;
                end
            end
            EXEC_S: begin
                // A prepared read covers exactly one following frame.
                next_r.rd_sel = 1'b0;
                next_r.idle = 1'b0;
                next_r.state = IDLE_S;
                case (cmd)
                    CMD_NOP: begin
                        next_r.idle = 1'b1;
                    end
                    CMD_LOAD: begin
                        if (chan2) begin
                            next_r.wiper2 = data[9:0];
                        end else begin
                            next_r.wiper1 = data[9:0];
                        end
                    end
                    CMD_INC: begin
                        if (chan2) begin
                            next_r.wiper2 = dvr_wiper_inc(r.wiper2);
                        end else begin
                            next_r.wiper1 = dvr_wiper_inc(r.wiper1);
                        end
                    end
                    CMD_SHIFT_L: begin
                        if (chan2) begin
                            next_r.wiper2 = dvr_wiper_dbl(r.wiper2);
                        end else begin
                            next_r.wiper1 = dvr_wiper_dbl(r.wiper1);
                        end
                    end
                    CMD_SAVE: begin
                        // Protection is checked on the synchronised pin level.
                        next_r.nv_we = r.wp_s2;
                        next_r.nv_waddr = chan2 ? ADDR_SLOT2 : ADDR_SLOT1;
                        next_r.nv_wdata = {WIPER_PAD, chan2 ? r.wiper2 : r.wiper1};
                    end
                    CMD_USER_WR: begin
                        // Addresses outside the user range are ignored.
                        if (addr >= ADDR_USER_FIRST && addr <= ADDR_USER_LAST) begin
                            next_r.nv_we = r.wp_s2;
                        end
                        next_r.nv_waddr = addr;
                        next_r.nv_wdata = data;
                    end
                    CMD_RESTORE: begin
                        if (chan2) begin
                            next_r.wiper2 = slot2[9:0];
                        end else begin
                            next_r.wiper1 = slot1[9:0];
                        end
                    end
                    CMD_RESTORE_ALL: begin
                        next_r.wiper1 = slot1[9:0];
                        next_r.wiper2 = slot2[9:0];
                    end
                    CMD_NV_RD: begin
                        // The store registers the addressed word this cycle.
                        next_r.state = FETCH_S;
                    end
                    CMD_WIPER_RD: begin
                        next_r.rd_word = {WIPER_PAD, chan2 ? r.wiper2 : r.wiper1};
                        next_r.rd_sel = 1'b1;
                    end
                    default: begin
                        // Unlisted codes change nothing but the echo.
                        next_r.idle = r.idle;
                    end
                endcase
            end
            FETCH_S: begin
                next_r.rd_word = nv_rdata;
                next_r.rd_sel = 1'b1;
                next_r.state = IDLE_S;
            end
            default: begin
                next_r.state = IDLE_S;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            r <= '0;
            r.state <= BOOT_S;
            r.pr_s1 <= 1'b1;
            r.pr_s2 <= 1'b1;
            r.wp_s1 <= 1'b1;
            r.wp_s2 <= 1'b1;
            r.wiper1 <= WIPER_MID;
            r.wiper2 <= WIPER_MID;
            r.idle <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wiper_reg_1_o = r.wiper1;
    assign wiper_reg_2_o = r.wiper2;
    assign idle_o = r.idle;

endmodule // dvr_top

// ==== dv/dvr_top_chk.sv ====
`timescale 1ns/1ps
// Watches the top ports: reset state, quiet hold and the serial echo.
module dvr_top_chk
    import dvr_pkg::*;
(
    // Clocks, reset and serial port.
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic serial_data_in_i,
    input wire logic serial_data_out_o,
    // Control pins and outputs.
    input wire logic preset_strobe_n_i,
    input wire logic write_protect_n_i,
    input wire logic [9:0] wiper_reg_1_o,
    input wire logic [9:0] wiper_reg_2_o,
    input wire logic idle_o
);
    logic [4:0] bit_cnt; // Rising edges taken in this frame.
    logic seen; // A whole frame has passed since reset.
    logic [23:0] hist; // Last 24 bits taken from the host.

    // The link clock stops, so this tally is cleared asynchronously.
    always_ff @(posedge spi_sclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bit_cnt <= 5'h00;
            seen <= 1'b0;
            hist <= 24'h000000;
        end else if (!spi_cs_n_i) begin
            hist <= {hist[22:0], serial_data_in_i};
            bit_cnt <= (bit_cnt == 5'h17) ? 5'h00 : bit_cnt + 5'h01;
            seen <= seen || (bit_cnt == 5'h17);
        end
    end

    sequence s_release;
        $fell(sys_rst_i);
    endsequence
    sequence s_quiet;
        (spi_cs_n_i && preset_strobe_n_i) [*8];
    endsequence
    sequence s_preset;
        (spi_cs_n_i && !preset_strobe_n_i) [*8];
    endsequence

    a_reset_mid: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_release |-> wiper_reg_1_o == WIPER_MID && wiper_reg_2_o == WIPER_MID)
        else $error("wipers not midscale at release");
    a_boot_load: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_release |-> ##2 wiper_reg_1_o == WIPER_MID && wiper_reg_2_o == WIPER_MID)
        else $error("wipers not restored after boot");
    a_boot_idle: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_release |-> idle_o [*3])
        else $error("idle lost after reset");
    a_sdo_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_release |-> !serial_data_out_o)
        else $error("serial out not cleared by reset");
    a_quiet_wipers: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_quiet |=> $stable(wiper_reg_1_o) && $stable(wiper_reg_2_o))
        else $error("wiper moved with no frame");
    a_quiet_idle: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        spi_cs_n_i [*8] |=> $stable(idle_o))
        else $error("idle moved with no frame");
    a_preset_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_preset |=> $stable(wiper_reg_1_o) && $stable(wiper_reg_2_o))
        else $error("wiper not held by preset");
    a_echo_head: assert property (@(posedge spi_sclk_i) disable iff (sys_rst_i)
        !spi_cs_n_i && seen && bit_cnt < 5'h08 |-> serial_data_out_o == hist[23])
        else $error("head byte not echoed");
endmodule // dvr_top_chk

bind dvr_top dvr_top_chk dvr_top_chk_i (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .spi_sclk_i(spi_sclk_i),
    .spi_cs_n_i(spi_cs_n_i),
    .serial_data_in_i(serial_data_in_i),
    .serial_data_out_o(serial_data_out_o),
    .preset_strobe_n_i(preset_strobe_n_i),
    .write_protect_n_i(write_protect_n_i),
    .wiper_reg_1_o(wiper_reg_1_o),
    .wiper_reg_2_o(wiper_reg_2_o),
    .idle_o(idle_o)
);

// ==== dv/dvr_host_model.sv ====
`timescale 1ns/1ps
// Serial host: sends whole frames in either clocking mode, idle between.
module dvr_host_model (
    // Serial pins toward the device.
    output logic spi_sclk_o,
    output logic spi_cs_n_o,
    output logic serial_data_in_o,
    input wire logic serial_data_out_i,
    // Word shifted back and a toggle per finished frame.
    output logic [23:0] rx_word_o,
    output logic frame_tgl_o
);
    localparam time HALF = 80; // Half of the 160 ns link period.

    initial begin
        spi_sclk_o = 1'b0;
        spi_cs_n_o = 1'b1;
        serial_data_in_o = 1'b0;
        rx_word_o = 24'h000000;
        frame_tgl_o = 1'b0;
    end

    // One frame, top bit first; the clock never moves as select rises.
    task automatic frame(input logic [23:0] w, input logic m3);
        #(HALF);
        spi_sclk_o = m3;
        #(HALF);
        spi_cs_n_o = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            if (m3) spi_sclk_o = 1'b0;
            serial_data_in_o = w[i];
            #(HALF);
            spi_sclk_o = 1'b1;
            rx_word_o = {rx_word_o[22:0], serial_data_out_i};
            #(HALF);
            if (!m3) spi_sclk_o = 1'b0;
        end
        // A released line shows the inverse.
        serial_data_in_o = ~w[0];
        #(2 * HALF);
        spi_cs_n_o = 1'b1;
        frame_tgl_o = ~frame_tgl_o;
    endtask
endmodule // dvr_host_model

// ==== dv/dual_rheostat_serial_command_decoder_bench.sv ====
`timescale 1ns/1ps
// Sends frames through the host model and checks echo, wipers and idle.
module dual_rheostat_serial_command_decoder_bench;
    import dvr_pkg::*;

    typedef struct packed {
        logic [23:0] serial_data_out;
        logic [9:0] w1;
        logic [9:0] w2;
        logic idle;
    } dvr_note_type;

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic preset_n = 1'b1;
    logic wp_n = 1'b1;
    logic sclk, cs_n, serial_data_in, serial_data_out, idle_flag, tgl;
    logic [9:0] w1, w2;
    logic [23:0] rx;
    int fails = 0;
    int checks_done = 0;
    dvr_note_type notes[$]; // One note per frame, oldest first.
    logic [9:0] w [2]; // Expected wipers.
    logic [15:0] nv [16]; // Expected nonvolatile store.
    logic [23:0] prev = 24'h000000;
    logic [15:0] rdw = 16'h0000;
    logic rd = 1'b0;
    logic first = 1'b1;
    logic ex_idle = 1'b1;

    initial begin
        forever #50 mclk = ~mclk;
    end

    dvr_top dvr_top_i (.mclk_i(mclk), .sys_rst_i(rst), .spi_sclk_i(sclk),
        .spi_cs_n_i(cs_n), .serial_data_in_i(serial_data_in), .serial_data_out_o(serial_data_out),
        .preset_strobe_n_i(preset_n), .write_protect_n_i(wp_n),
        .wiper_reg_1_o(w1), .wiper_reg_2_o(w2), .idle_o(idle_flag));
    dvr_host_model dvr_host_model_i (.spi_sclk_o(sclk), .spi_cs_n_o(cs_n),
        .serial_data_in_o(serial_data_in), .serial_data_out_i(serial_data_out), .rx_word_o(rx),
        .frame_tgl_o(tgl));

    task automatic cmp_word(input string n, input logic [23:0] e, input logic [23:0] s);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cmp_wiper(input string n, input logic [9:0] e, input logic [9:0] s);
        cmp_word(n, 24'(e), 24'(s));
    endtask
    task automatic cmp_flag(input string n, input logic e, input logic s);
        cmp_word(n, 24'(e), 24'(s));
    endtask

    // Lets the last frame be decoded before the write guard may change.
    task automatic gap(input logic v);
        repeat (8) @(posedge mclk);
        wp_n <= v;
        @(posedge mclk);
    endtask

    // Notes the expected echo and prior state, updates the model, sends.
    task automatic send(input logic [23:0] f);
        logic [3:0] c;
        logic [3:0] a;
        logic ch;
        dvr_note_type n;
        c = f[23:20];
        a = f[19:16];
        ch = (a == 4'h1);
        n.serial_data_out = first ? 24'h000000 : {prev[23:16], rd ? rdw : prev[15:0]};
        n.w1 = w[0];
        n.w2 = w[1];
        n.idle = ex_idle;
        notes.push_back(n);
        first = 1'b0;
        rd = 1'b0;
        prev = f;
        if (c inside {[4'h1:4'h3], [4'h8:4'hc], 4'he}) ex_idle = 1'b0;
        case (c)
            CMD_NOP: ex_idle = 1'b1;
            CMD_RESTORE: w[ch] = nv[ch][9:0];
            CMD_SAVE: if (wp_n) nv[ch] = {6'h00, w[ch]};
            CMD_USER_WR: if (wp_n && a inside {[4'h2:4'he]}) nv[a] = f[15:0];
            CMD_RESTORE_ALL: begin
                w[0] = nv[0][9:0];
                w[1] = nv[1][9:0];
            end
            CMD_NV_RD: begin
                rd = 1'b1;
                rdw = nv[a];
            end
            CMD_WIPER_RD: begin
                rd = 1'b1;
                rdw = {6'h00, w[ch]};
            end
            CMD_LOAD: w[ch] = f[9:0];
            CMD_SHIFT_L: w[ch] = w[ch][9] ? 10'h3ff : {w[ch][8:0], 1'b0};
            CMD_INC: w[ch] = (w[ch] == 10'h3ff) ? w[ch] : w[ch] + 10'h001;
            default: ;
        endcase
        dvr_host_model_i.frame(f, 1'($urandom_range(1)));
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Each finished frame settles the oldest note.
    initial begin
        dvr_note_type n;
        wait (!rst);
        forever begin
            @(tgl);
            n = notes.pop_front();
            cmp_word("serial_data_out", n.serial_data_out, rx);
            cmp_wiper("wiper_reg_1", n.w1, w1);
            cmp_wiper("wiper_reg_2", n.w2, w2);
            cmp_flag("idle", n.idle, idle_flag);
        end
    end

    // Some 70 frames of 4.16 us; a hang is cut off well after.
    initial begin
        #1000000;
        fails++;
        report_and_stop();
    end

    initial begin
        for (int i = 0; i < 16; i++) begin
            nv[i] = (i < 2) ? 16'h0200 : 16'h0000;
        end
        w[0] = WIPER_MID;
        w[1] = WIPER_MID;
        void'($urandom(97));
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        send(24'hb00100);
        send(24'hb10200);
        send(24'he00000);
        send(24'he00000);
        send(24'h200000);
        send(24'hb003ff);
        send(24'he00000);
        send(24'h100000);
        send(24'h000000);
        send(24'h800000);
        send(24'h32aaaa);
        send(24'h335555);
        send(24'h3e1234);
        send(24'h3f4321);
        send(24'h920000);
        send(24'h000000);
        send(24'h9e0000);
        send(24'hb00200);
        send(24'hc00000);
        send(24'ha00000);
        send(24'hc10000);
        send(24'ha10000);
        gap(1'b0);
        send(24'hb00155);
        send(24'h200000);
        send(24'h32beef);
        send(24'h100000);
        send(24'h920000);
        gap(1'b1);
        send(24'hb00011);
        send(24'hb10022);
        gap(1'b1);
        preset_n <= 1'b0;
        repeat (12) @(posedge mclk);
        preset_n <= 1'b1;
        w[0] = nv[0][9:0];
        w[1] = nv[1][9:0];
        repeat (4) @(posedge mclk);
        repeat (40) begin
            gap(1'($urandom_range(1)));
            send(24'($urandom()));
        end
        gap(1'b1);
        send(24'h000000);
        repeat (10) @(posedge mclk);
        report_and_stop();
    end
endmodule // dual_rheostat_serial_command_decoder_bench
